// *** hdl/gpio_sel_pkg.sv ***
// Package for the status-signal pin selector: codes, offsets, fields, carriers
`default_nettype none

package gpio_sel_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned CODE_W = 6;
  localparam int unsigned GAIN_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Select codes handled by this block
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_FIFO_ERR = 6'h27;   // 39
  localparam logic [5:0] CODE_DEMOD = 6'h28;      // 40
  localparam logic [5:0] CODE_SYNC = 6'h29;       // 41
  localparam logic [5:0] CODE_RAMP = 6'h2A;       // 42
  localparam logic [5:0] CODE_PKT_ERR = 6'h2B;    // 43
  localparam logic [5:0] CODE_GAIN_OK = 6'h2C;    // 44
  localparam logic [5:0] CODE_GAIN_UPD = 6'h2D;   // 45
  localparam logic [5:0] CODE_ADC = 6'h2E;        // 46
  localparam int unsigned CODE_SPAN = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_SELECT = 8'h00;
  localparam logic [7:0] OFS_MODEM_CONFIG_ONE = 8'h04;
  localparam logic [7:0] OFS_DEMODULATOR_STATE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SEL_FIELD_STRIDE = 8;       // Pin n code at bits 8n+5..8n
  localparam int unsigned CFG_COLLISION_EN_BIT = 0;
  localparam int unsigned ST_COLLISION_FOUND_BIT = 0;
  localparam int unsigned ST_RC_CAL_BIT = 1;
  localparam int unsigned ST_FILTER_SETTLED_BIT = 2;
  localparam int unsigned ST_GAIN_SETTLED_BIT = 3;
  localparam int unsigned ST_TX_OVERRUN_BIT = 4;
  localparam int unsigned ST_RX_UNDERRUN_BIT = 5;
  localparam int unsigned EVENT_COUNT = 5;            // Overrun, underrun, sync, collision, gain
  localparam logic [31:0] PIN_SELECT_RESET = 32'h0000_0000;
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam logic MODEM_CONFIG_RESET = 1'b0;
  localparam logic [4:0] IRQ_RESET = 5'h00;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_overrun_set;         // Transmit buffer written while full (pulse)
    logic tx_flush;               // Transmit buffer flushed (pulse)
    logic rx_underrun_set;        // Receive buffer read while empty (pulse)
    logic rx_flush;               // Receive buffer flushed (pulse)
    logic magnitude_sample_strobe;
    logic channel_filter_sample_strobe;
    logic rc_cal_done;            // One oscillator calibration finished (pulse)
    logic channel_filter_settled;
    logic sync_found;             // Sync word detected (pulse)
    logic receiving;              // Packet reception under way
    logic amplifier_ramp_start;
    logic checksum_mismatch_flag;
    logic bad_length_flag;
    logic address_mismatch_flag;
    logic uart_framing_flag;
    logic adc_clock;
    logic adc_i_sample;
    logic adc_q_sample;
  } status_src_s;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;      // Present front-end gain setting
    logic rssi_estimate_strobe;   // New internal signal strength estimate
  } gain_src_s;

endpackage : gpio_sel_pkg

`default_nettype wire

// *** hdl/gain_watch.sv ***
// Gain loop watcher: settled flag and gain-change pulse
`default_nettype none

module gain_watch (
  input wire logic clk,                          // 100 MHz clock
  input wire logic rst_b,                        // Synchronous reset, active low
  input wire gpio_sel_pkg::gain_src_s src,       // Gain value and estimate strobe
  output logic gain_settled,                     // Present gain equals previous one
  output logic gain_changed_pulse                // One cycle per gain adjustment
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [gpio_sel_pkg::GAIN_W-1:0] last_gain_q;    // Gain seen on the previous cycle
  logic [gpio_sel_pkg::GAIN_W-1:0] eval_gain_q;    // Gain at the previous estimate
  logic settled_q;
  logic pulse_q;
  wire gain_moved = (src.gain != last_gain_q);
  wire settled_d = (src.gain == eval_gain_q);

  // Change pulse follows any move of the gain word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last_gain_q <= gpio_sel_pkg::GAIN_RESET;
      pulse_q <= 1'b0;
    end else begin
      last_gain_q <= src.gain;
      pulse_q <= gain_moved;
    end
  end

  // Compare only on a new estimate, so the flag holds between estimates
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eval_gain_q <= gpio_sel_pkg::GAIN_RESET;
      settled_q <= 1'b0;
    end else if (src.rssi_estimate_strobe) begin
      eval_gain_q <= src.gain;
      settled_q <= settled_d;
    end
  end

  assign gain_settled = settled_q;
  assign gain_changed_pulse = pulse_q;

endmodule : gain_watch

`default_nettype wire

// *** hdl/gpio_status_signal_select.sv ***
// Status, event and test signal selector for the four output pins, codes 39 to 46
//
// Notes on behaviour
// - Code 39 on pin 2 shows transmit buffer overrun.
// - Code 39 on pin 0 shows receive buffer underrun.
// - Code 40 on pin 3 strobes each new magnitude sample.
// - Code 40 on pin 2 strobes each new channel filter sample.
// - Code 40 on pin 1 stays high once oscillator calibration has finished.
// - Code 40 on pin 0 shows the channel filter has settled.
// - Code 41 pins 3 and 1 flag a later sync in a packet, if enabled.
// - Code 42 shows the amplifier ramp start.
// - Code 44 reports gain settled when present gain equals previous gain.
// - Gain settled comparison is refreshed on each new strength estimate.
// - Code 45 pulses once for every gain change.
// - Code 46 routes converter samples and clock, clock on pin 3.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`default_nettype none

module gpio_status_signal_select (
  input wire logic clk,                                   // 100 MHz clock
  input wire logic rst_b,                                 // Synchronous reset, active low
  input wire logic [gpio_sel_pkg::ADDR_W-1:0] reg_addr,   // Register byte address
  input wire logic [gpio_sel_pkg::DATA_W-1:0] reg_wdata,  // Register write data
  input wire logic reg_wr,                                // Write strobe
  input wire logic reg_rd,                                // Read strobe
  output logic [gpio_sel_pkg::DATA_W-1:0] reg_rdata,      // Read data, cycle after strobe
  input wire gpio_sel_pkg::status_src_s src,              // Internal status sources
  input wire gpio_sel_pkg::gain_src_s gain_src,           // Gain loop sources
  output logic [gpio_sel_pkg::PIN_COUNT-1:0] gpio_out,    // Pin output levels
  output logic [gpio_sel_pkg::PIN_COUNT-1:0] gpio_oe,     // Pin output enables
  output logic irq                                        // Level interrupt
);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire hit_sel = (reg_addr == gpio_sel_pkg::OFS_PIN_SELECT);
  wire hit_cfg = (reg_addr == gpio_sel_pkg::OFS_MODEM_CONFIG_ONE);
  wire hit_state = (reg_addr == gpio_sel_pkg::OFS_DEMODULATOR_STATE);
  wire hit_ist = (reg_addr == gpio_sel_pkg::OFS_IRQ_STATUS);
  wire hit_imask = (reg_addr == gpio_sel_pkg::OFS_IRQ_MASK);
  wire wr_sel = reg_wr && hit_sel;
  wire wr_cfg = reg_wr && hit_cfg;
  wire wr_ist = reg_wr && hit_ist;
  wire wr_imask = reg_wr && hit_imask;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [gpio_sel_pkg::CODE_W-1:0] code_q [gpio_sel_pkg::PIN_COUNT];
  logic collision_en_q;
  logic [gpio_sel_pkg::EVENT_COUNT-1:0] irq_status_q;
  logic [gpio_sel_pkg::EVENT_COUNT-1:0] irq_mask_q;
  logic [gpio_sel_pkg::DATA_W-1:0] rdata_q;

  // Per-pin select codes, one field per pin
  generate
    for (genvar p = 0; p < gpio_sel_pkg::PIN_COUNT; p++) begin : g_code
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          code_q[p] <= gpio_sel_pkg::CODE_RESET;
        end else if (wr_sel) begin
          code_q[p] <= reg_wdata[p*gpio_sel_pkg::SEL_FIELD_STRIDE +: gpio_sel_pkg::CODE_W];
        end
      end
    end
  endgenerate

  // Collision detection enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      collision_en_q <= gpio_sel_pkg::MODEM_CONFIG_RESET;
    end else if (wr_cfg) begin
      collision_en_q <= reg_wdata[gpio_sel_pkg::CFG_COLLISION_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sticky status derived from source events
  // ----------------------------------------------------------------
  logic tx_overrun_q;
  logic rx_underrun_q;
  logic rc_cal_q;
  logic collision_found_q;
  logic gain_settled;
  logic gain_changed_pulse;

  // Overrun and underrun hold until the buffer is flushed; a new error wins over flush
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_overrun_q <= 1'b0;
      rx_underrun_q <= 1'b0;
    end else begin
      tx_overrun_q <= src.tx_overrun_set || (tx_overrun_q && !src.tx_flush);
      rx_underrun_q <= src.rx_underrun_set || (rx_underrun_q && !src.rx_flush);
    end
  end

  // Calibration flag never falls again until reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rc_cal_q <= 1'b0;
    end else if (src.rc_cal_done) begin
      rc_cal_q <= 1'b1;
    end
  end

  // A sync inside an ongoing packet is a collision; cleared when reception ends
  wire collision_event = src.sync_found && src.receiving;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      collision_found_q <= 1'b0;
    end else if (collision_event && collision_en_q) begin
      collision_found_q <= 1'b1;
    end else if (!src.receiving) begin
      collision_found_q <= 1'b0;
    end
  end

  // Gain loop tracking lives in its own small module
  gain_watch i_gain_watch (
    .clk(clk),
    .rst_b(rst_b),
    .src(gain_src),
    .gain_settled(gain_settled),
    .gain_changed_pulse(gain_changed_pulse)
  );

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [gpio_sel_pkg::EVENT_COUNT-1:0] irq_events = {
    gain_changed_pulse, collision_event, src.sync_found,
    src.rx_underrun_set, src.tx_overrun_set};
  wire [gpio_sel_pkg::EVENT_COUNT-1:0] irq_clear =
    wr_ist ? reg_wdata[gpio_sel_pkg::EVENT_COUNT-1:0] : gpio_sel_pkg::IRQ_RESET;

  // Write one to clear; an event in the clearing cycle still sets the bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_status_q <= gpio_sel_pkg::IRQ_RESET;
      irq_mask_q <= gpio_sel_pkg::IRQ_RESET;
    end else begin
      irq_status_q <= irq_events | (irq_status_q & ~irq_clear);
      if (wr_imask) begin
        irq_mask_q <= reg_wdata[gpio_sel_pkg::EVENT_COUNT-1:0];
      end
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [gpio_sel_pkg::DATA_W-1:0] sel_word;
  logic [gpio_sel_pkg::DATA_W-1:0] state_word;
  always_comb begin
    sel_word = '0;
    for (int p = 0; p < gpio_sel_pkg::PIN_COUNT; p++) begin
      sel_word[p*gpio_sel_pkg::SEL_FIELD_STRIDE +: gpio_sel_pkg::CODE_W] = code_q[p];
    end
  end

  // Live status bits for software polling
  always_comb begin
    state_word = '0;
    state_word[gpio_sel_pkg::ST_COLLISION_FOUND_BIT] = collision_found_q;
    state_word[gpio_sel_pkg::ST_RC_CAL_BIT] = rc_cal_q;
    state_word[gpio_sel_pkg::ST_FILTER_SETTLED_BIT] = src.channel_filter_settled;
    state_word[gpio_sel_pkg::ST_GAIN_SETTLED_BIT] = gain_settled;
    state_word[gpio_sel_pkg::ST_TX_OVERRUN_BIT] = tx_overrun_q;
    state_word[gpio_sel_pkg::ST_RX_UNDERRUN_BIT] = rx_underrun_q;
  end

  wire [gpio_sel_pkg::DATA_W-1:0] rd_mux =
    hit_sel ? sel_word :
    hit_cfg ? {31'h0000_0000, collision_en_q} :
    hit_state ? state_word :
    hit_ist ? {27'h000_0000, irq_status_q} :
    hit_imask ? {27'h000_0000, irq_mask_q} :
    32'h0000_0000;

  // Data valid only in the cycle after the read strobe; zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Per-code signal vectors, bit n goes to pin n
  // ----------------------------------------------------------------
  logic [gpio_sel_pkg::PIN_COUNT-1:0] code_vec [gpio_sel_pkg::CODE_SPAN];

  // Reserved test slots of code 39 drive low
  assign code_vec[0] = {1'b0, tx_overrun_q, 1'b0, rx_underrun_q};
  assign code_vec[1] = {src.magnitude_sample_strobe, src.channel_filter_sample_strobe,
                        rc_cal_q, src.channel_filter_settled};
  assign code_vec[2] = {collision_found_q, src.sync_found,
                        collision_found_q, collision_event};
  assign code_vec[3] = {4{src.amplifier_ramp_start}};
  assign code_vec[4] = {src.checksum_mismatch_flag, src.bad_length_flag,
                        src.address_mismatch_flag, src.uart_framing_flag};
  assign code_vec[5] = {4{gain_settled}};
  assign code_vec[6] = {4{gain_changed_pulse}};
  // Converter data is test only; the clock on pins 3 and 1 is resampled by clk
  assign code_vec[7] = {src.adc_clock, src.adc_q_sample,
                        src.adc_clock, src.adc_i_sample};

  // ----------------------------------------------------------------
  // Pin multiplexer
  // ----------------------------------------------------------------
  // Codes outside 39..46 belong to other selectors, so this block releases the pin
  generate
    for (genvar p = 0; p < gpio_sel_pkg::PIN_COUNT; p++) begin : g_pin
      wire in_range = (code_q[p] >= gpio_sel_pkg::CODE_FIFO_ERR) &&
                      (code_q[p] <= gpio_sel_pkg::CODE_ADC);
      wire [2:0] slot = 3'(code_q[p] - gpio_sel_pkg::CODE_FIFO_ERR);
      wire pin_d = in_range ? code_vec[slot][p] : 1'b0;
      logic out_q;
      logic oe_q;
      // Registered so each pin sees a glitch-free level, at one cycle of delay
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          out_q <= 1'b0;
          oe_q <= 1'b0;
        end else begin
          out_q <= pin_d;
          oe_q <= in_range;
        end
      end
      assign gpio_out[p] = out_q;
      assign gpio_oe[p] = oe_q;
    end
  endgenerate

endmodule : gpio_status_signal_select

`default_nettype wire

// *** verif/gpio_sel_sva.sv ***
// Assertion checker for the status-signal pin selector, bound to its top module
`default_nettype none

module gpio_sel_sva (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [gpio_sel_pkg::ADDR_W-1:0] reg_addr, // Address
  input wire logic [gpio_sel_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [gpio_sel_pkg::DATA_W-1:0] reg_rdata, // Read data
  input wire gpio_sel_pkg::status_src_s src, // Status sources
  input wire gpio_sel_pkg::gain_src_s gain_src, // Gain sources
  input wire logic [gpio_sel_pkg::PIN_COUNT-1:0] gpio_out, // Pin levels
  input wire logic [gpio_sel_pkg::PIN_COUNT-1:0] gpio_oe, // Pin enables
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sel_q;
  logic [2:0] run_q;
  wire logic sel_wr = reg_wr && (reg_addr == gpio_sel_pkg::OFS_PIN_SELECT);
  wire logic [5:0] c0_w = sel_q[5:0];
  wire logic [5:0] c1_w = sel_q[13:8];
  wire logic [5:0] c2_w = sel_q[21:16];
  wire logic [5:0] c3_w = sel_q[29:24];
  // Shadow of the select register; run_q keeps history checks clear of reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_q <= 32'h0000_0000;
      run_q <= 3'h0;
    end else begin
      if (sel_wr) sel_q <= reg_wdata;
      if (run_q != 3'h7) run_q <= run_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_oe_from_code: assert property (gpio_oe[0] ==
    ($past(c0_w) inside {[gpio_sel_pkg::CODE_FIFO_ERR:gpio_sel_pkg::CODE_ADC]}))
    else $error("pin enable does not follow select code");
  a_fifo_spare_low: assert property ($past(c3_w) == gpio_sel_pkg::CODE_FIFO_ERR |->
    !gpio_out[3] && gpio_oe[3]) else $error("spare pin of code 39 not driven low");
  a_underrun_shown: assert property (run_q >= 3'h2
    && $past(c0_w) == gpio_sel_pkg::CODE_FIFO_ERR
    && $past(src.rx_underrun_set, 2) && !$past(src.rx_flush, 2) |-> gpio_out[0])
    else $error("underrun not shown on pin 0");
  a_magn_strobe: assert property ($past(c3_w) == gpio_sel_pkg::CODE_DEMOD |->
    gpio_out[3] == $past(src.magnitude_sample_strobe)) else $error("magnitude strobe lost");
  a_rc_cal_holds: assert property ($past(c1_w) == gpio_sel_pkg::CODE_DEMOD &&
    $past(c1_w, 2) == gpio_sel_pkg::CODE_DEMOD && $past(gpio_out[1]) |-> gpio_out[1])
    else $error("calibration flag dropped");
  a_sync_pulse: assert property ($past(c2_w) == gpio_sel_pkg::CODE_SYNC |->
    gpio_out[2] == $past(src.sync_found)) else $error("sync pulse mismatch");
  a_ramp_follows: assert property ($past(c0_w) == gpio_sel_pkg::CODE_RAMP |->
    gpio_out[0] == $past(src.amplifier_ramp_start)) else $error("ramp start mismatch");
  a_addr_error: assert property ($past(c1_w) == gpio_sel_pkg::CODE_PKT_ERR |->
    gpio_out[1] == $past(src.address_mismatch_flag)) else $error("address error mismatch");
  a_settled_holds: assert property (run_q >= 3'h3
    && $past(c0_w) == gpio_sel_pkg::CODE_GAIN_OK
    && $past(c0_w, 2) == gpio_sel_pkg::CODE_GAIN_OK && !$past(gain_src.rssi_estimate_strobe, 2)
    |-> $stable(gpio_out[0])) else $error("settled flag moved without estimate");
  a_gain_pulse: assert property (run_q >= 3'h3
    && $past(c0_w) == gpio_sel_pkg::CODE_GAIN_UPD
    |-> gpio_out[0] == ($past(gain_src.gain, 2) != $past(gain_src.gain, 3)))
    else $error("gain change pulse mismatch");
  a_adc_clock: assert property ($past(c3_w) == gpio_sel_pkg::CODE_ADC |->
    gpio_out[3] == $past(src.adc_clock)) else $error("converter clock not on pin 3");
endmodule : gpio_sel_sva

bind gpio_status_signal_select gpio_sel_sva i_gpio_sel_sva (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .src(src), .gain_src(gain_src), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .irq(irq));

`default_nettype wire

// *** verif/host_pin_monitor.sv ***
// Host microcontroller model that reads the four output pins
`default_nettype none

module host_pin_monitor (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [3:0] gpio_out, // Pin drive levels
  input wire logic [3:0] gpio_oe, // Pin drive enables
  output logic [3:0] pin_level, // Level the host reads
  output logic [7:0] rise_cnt_q // Rising edges seen on pin 0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  // Released pins read low through the board pull-downs
  assign pin_level = gpio_out & gpio_oe;
  // Count pulses so a merged or missing pulse shows up
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last_q <= 1'b0;
      rise_cnt_q <= 8'h00;
    end else begin
      last_q <= pin_level[0];
      if (pin_level[0] && !last_q) rise_cnt_q <= rise_cnt_q + 8'h01;
    end
  end
endmodule : host_pin_monitor

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the status-signal pin selector
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int unsigned due; logic [31:0] v; logic [31:0] m;} note_s;
  logic clk, rst_b, reg_wr, reg_rd, irq, rd_pend;
  logic [7:0] reg_addr, rises, r0;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] gpio_out, gpio_oe, pin_level;
  gpio_sel_pkg::status_src_s src, s;
  gpio_sel_pkg::gain_src_s gain_src;
  int unsigned cyc, mismatches, n_tests;
  note_s rdq[$], pinq[$], wn;

  gpio_status_signal_select i_gpio_status_signal_select (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src(src), .gain_src(gain_src), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .irq(irq));
  host_pin_monitor i_host_pin_monitor (.clk(clk), .rst_b(rst_b), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pin_level(pin_level), .rise_cnt_q(rises));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rdq.push_back('{0, e, m});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Drive sources after an edge; the pins show them two edges later
  task automatic put(input gpio_sel_pkg::status_src_s x, input logic [8:0] g,
                     input logic [9:0] e);
    @(posedge clk);
    src <= x;
    gain_src <= gpio_sel_pkg::gain_src_s'(g);
    pinq.push_back('{cyc + 2, {27'h0, e[4:0]}, {27'h0, e[9:5]}});
  endtask : put

  // Expected {care, irq and pins} for the pass-through sources of one code
  function automatic logic [9:0] exp_pins(input logic [5:0] c,
                                          input gpio_sel_pkg::status_src_s x);
    case (c)
      gpio_sel_pkg::CODE_DEMOD: return {5'h1D, 1'b0, x.magnitude_sample_strobe,
        x.channel_filter_sample_strobe, 1'b0, x.channel_filter_settled};
      gpio_sel_pkg::CODE_SYNC: return {5'h15, 2'b00, x.sync_found, 1'b0,
        x.sync_found & x.receiving};
      gpio_sel_pkg::CODE_RAMP: return {5'h1F, 1'b0, {4{x.amplifier_ramp_start}}};
      gpio_sel_pkg::CODE_PKT_ERR: return {5'h1F, 1'b0, x.checksum_mismatch_flag,
        x.bad_length_flag, x.address_mismatch_flag, x.uart_framing_flag};
      gpio_sel_pkg::CODE_ADC: return {5'h1F, 1'b0, x.adc_clock, x.adc_q_sample,
        x.adc_clock, x.adc_i_sample};
      gpio_sel_pkg::CODE_GAIN_OK: return 10'h200;
      default: return 10'h3E0;
    endcase
  endfunction : exp_pins

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watcher: each result is compared with the oldest note once it falls due
  always @(posedge clk) begin
    cyc <= cyc + 1;
    while (pinq.size() > 0 && pinq[0].due == cyc) begin
      wn = pinq.pop_front();
      check({27'h0, irq, pin_level} & wn.m, wn.v);
    end
    if (rd_pend) begin
      wn = rdq.pop_front();
      check(reg_rdata & wn.m, wn.v);
    end
    rd_pend = reg_rd;
    if (cyc > 5000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src = '0;
    gain_src = '0;
    s = '0;
    rd_pend = 1'b0;
    cyc = 0;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(33487));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(gpio_sel_pkg::OFS_PIN_SELECT, 32'h0, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF);
    // Codes 38 to 47 with random pass-through sources; sticky sources held off
    // Neighbours 38 and 47 belong to other selectors, so the pins must be released
    for (int c = 38; c <= 47; c++) begin
      wr(gpio_sel_pkg::OFS_PIN_SELECT, {4{2'b00, 6'(c)}});
      repeat (6) begin
        s = gpio_sel_pkg::status_src_s'(18'($urandom) & 18'h037FF);
        put(s, 9'h000, exp_pins(6'(c), s));
      end
      check({28'h0, gpio_oe}, (c >= 39 && c <= 46) ? 32'h0000_000F : 32'h0000_0000);
    end
    s = '0;
    wr(gpio_sel_pkg::OFS_IRQ_STATUS, 32'h1F);
    wr(gpio_sel_pkg::OFS_IRQ_MASK, 32'h01);
    wr(gpio_sel_pkg::OFS_PIN_SELECT, 32'h2727_2727);
    put('{tx_overrun_set: 1'b1, default: 1'b0}, 9'h000, 10'h000);
    put(s, 9'h000, 10'h3F4);
    put('{rx_underrun_set: 1'b1, default: 1'b0}, 9'h000, 10'h000);
    put(s, 9'h000, 10'h3F5);
    rd(gpio_sel_pkg::OFS_IRQ_STATUS, 32'h03, 32'h03);
    wr(gpio_sel_pkg::OFS_IRQ_STATUS, 32'h01);
    put(s, 9'h000, 10'h3E5);
    put('{tx_flush: 1'b1, default: 1'b0}, 9'h000, 10'h000);
    put(s, 9'h000, 10'h3E1);
    rd(gpio_sel_pkg::OFS_DEMODULATOR_STATE, 32'h20, 32'h30);
    // Calibration flag must stay up long after its one-cycle source
    wr(gpio_sel_pkg::OFS_PIN_SELECT, 32'h2828_2828);
    put('{rc_cal_done: 1'b1, default: 1'b0}, 9'h000, 10'h000);
    repeat (4) put(s, 9'h000, 10'h3E2);
    // Later sync in a packet, first with collision detection on, then off
    wr(gpio_sel_pkg::OFS_PIN_SELECT, 32'h2929_2929);
    for (int en = 1; en >= 0; en--) begin
      wr(gpio_sel_pkg::OFS_MODEM_CONFIG_ONE, 32'(en));
      put('{receiving: 1'b1, sync_found: 1'b1, default: 1'b0}, 9'h000, 10'h000);
      put('{receiving: 1'b1, default: 1'b0}, 9'h000,
          {5'h1F, 1'b0, en[0], 1'b0, en[0], 1'b0});
      put(s, 9'h000, 10'h000);
      put(s, 9'h000, 10'h3E0);
    end
    // Gain loop: settled on pins 3 and 2, change pulses on pins 1 and 0
    wr(gpio_sel_pkg::OFS_PIN_SELECT, 32'h2C2C_2D2D);
    repeat (3) @(posedge clk);
    r0 = rises;
    put(s, 9'h00B, 10'h000);
    put(s, 9'h00A, 10'h3E3);
    put(s, 9'h00A, 10'h3E0);
    put(s, 9'h00B, 10'h3E0);
    put(s, 9'h00E, 10'h3EC);
    put(s, 9'h00E, 10'h3EF);
    put(s, 9'h00F, 10'h3EC);
    put(s, 9'h00E, 10'h3E0);
    // Sticky events left by the tests above: underrun, sync, collision, gain change
    rd(gpio_sel_pkg::OFS_IRQ_STATUS, 32'h1E, 32'h1F);
    repeat (4) @(posedge clk);
    check({24'h0, rises}, {24'h0, r0 + 8'h02});
    finish_test();
  end
endmodule : testbench

`default_nettype wire
